// File: src/utw_window_map.sv
`timescale 1ns/1ps
module utw_window_map (
	input  wire logic                  sys_clk_i,
	input  wire logic                  nrst_i,
	input  wire logic                  ce_i,
	input  wire utw_pkg::utw_reg_req_s reg_req_i,
	output logic [utw_pkg::DATA_W-1:0] reg_rdata_o,
	output logic                       reg_rvalid_o,
	input  wire logic                  global_iso_permit_i,
	input  wire utw_pkg::utw_up_req_s  up_req_i,
	output utw_pkg::utw_up_map_s       up_map_o
);

	// ---------------------------------------------------------------
	// Register decode
	// ---------------------------------------------------------------
	// Shared by the read and write paths so both agree on which offsets
	// exist; every other offset falls through as a miss
	function automatic utw_pkg::utw_dec_s decode(input logic [utw_pkg::ADDR_W-1:0] a);
		utw_pkg::utw_dec_s d;
		d = '0;
		d.hit = 1'b1;
		unique case (a)
			utw_pkg::OFS_WIN1_CONTROL: begin
				d.idx  = 1'b0;
				d.kind = utw_pkg::KIND_CTRL;
			end
			utw_pkg::OFS_WIN1_BASE: begin
				d.idx  = 1'b0;
				d.kind = utw_pkg::KIND_BASE;
			end
			utw_pkg::OFS_WIN1_LIMIT: begin
				d.idx  = 1'b0;
				d.kind = utw_pkg::KIND_LIMIT;
			end
			utw_pkg::OFS_WIN2_CONTROL: begin
				d.idx  = 1'b1;
				d.kind = utw_pkg::KIND_CTRL;
			end
			utw_pkg::OFS_WIN2_BASE: begin
				d.idx  = 1'b1;
				d.kind = utw_pkg::KIND_BASE;
			end
			utw_pkg::OFS_WIN2_LIMIT: begin
				d.idx  = 1'b1;
				d.kind = utw_pkg::KIND_LIMIT;
			end
			default: begin
				d.hit = 1'b0;
			end
		endcase
		return d;
	endfunction

	// ---------------------------------------------------------------
	// Byte merge
	// ---------------------------------------------------------------
	// Byte enables let software move one byte of a bound without a
	// read-modify-write of the whole word
	function automatic logic [utw_pkg::DATA_W-1:0] merge(
		input logic [utw_pkg::DATA_W-1:0] old_v,
		input logic [utw_pkg::DATA_W-1:0] new_v,
		input logic [utw_pkg::BE_W-1:0]   be
	);
		logic [utw_pkg::DATA_W-1:0] r;
		r = old_v;
		for (int b = 0; b < utw_pkg::BE_W; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// ---------------------------------------------------------------
	// Window range
	// ---------------------------------------------------------------
	// Inclusive at both ends; a base above the limit leaves the window empty
	function automatic logic in_window(
		input logic [utw_pkg::DATA_W-1:0] a,
		input utw_pkg::utw_win_s          w
	);
		return (a >= w.base) && (a <= w.limit);
	endfunction

	// ---------------------------------------------------------------
	// Control word layout
	// ---------------------------------------------------------------
	// Only the enable and class fields are stored, so the reserved upper
	// bits read zero whatever was written to them
	function automatic logic [utw_pkg::CTRL_W-1:0] ctrl_word(input utw_pkg::utw_win_s w);
		logic [utw_pkg::CTRL_W-1:0] r;
		r = utw_pkg::CTRL_RST;
		r[utw_pkg::CTRL_EN_BIT] = w.window_map_enable;
		r[utw_pkg::CTRL_CLS_MSB:utw_pkg::CTRL_CLS_LSB] = w.class_select;
		return r;
	endfunction

	// ---------------------------------------------------------------
	// Class select
	// ---------------------------------------------------------------
	// Window 1 is visited last so it wins where two ranges overlap.
	// Without a hit the class stays zero, which is always a legal class.
	function automatic utw_pkg::utw_up_map_s pick_map(
		input logic                        valid,
		input logic [utw_pkg::NUM_WIN-1:0] hits,
		input utw_pkg::utw_state_s         s
	);
		utw_pkg::utw_up_map_s m;
		m              = '0;
		m.valid        = valid;
		m.class_select = utw_pkg::CLASS_ZERO;
		if (valid) begin
			for (int i = utw_pkg::NUM_WIN - 1; i >= 0; i--) begin
				if (hits[i]) begin
					m.hit          = 1'b1;
					m.class_select = s.win[i].class_select;
				end
			end
		end
		return m;
	endfunction

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	utw_pkg::utw_state_s         st_r;
	utw_pkg::utw_state_s         st_nxt;
	utw_pkg::utw_dec_s           wdec;
	utw_pkg::utw_dec_s           rdec;
	logic [utw_pkg::NUM_WIN-1:0] win_hit;

	// ---------------------------------------------------------------
	// Window match
	// ---------------------------------------------------------------
	// One comparator pair per window. The enable and the global permit
	// gate each match, so a disabled window never steers traffic.
	generate
		for (genvar g = 0; g < utw_pkg::NUM_WIN; g++) begin : g_win
			assign win_hit[g] = st_r.win[g].window_map_enable
				&& global_iso_permit_i
				&& in_window(up_req_i.addr, st_r.win[g]);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.rd_valid = 1'b0;
		wdec = decode(reg_req_i.addr);
		rdec = decode(reg_req_i.addr);

		// Register writes; reserved control bits are simply not stored
		if (reg_req_i.wr && wdec.hit) begin
			unique case (wdec.kind)
				utw_pkg::KIND_CTRL: begin
					// Only the low byte carries writable control bits
					if (reg_req_i.be[0]) begin
						st_nxt.win[wdec.idx].window_map_enable =
							reg_req_i.wdata[utw_pkg::CTRL_EN_BIT];
						st_nxt.win[wdec.idx].class_select =
							reg_req_i.wdata[utw_pkg::CTRL_CLS_MSB:utw_pkg::CTRL_CLS_LSB];
					end
				end
				utw_pkg::KIND_BASE: begin
					// Stored regardless of the enable bit
					st_nxt.win[wdec.idx].base = merge(st_r.win[wdec.idx].base,
						reg_req_i.wdata, reg_req_i.be);
				end
				utw_pkg::KIND_LIMIT: begin
					st_nxt.win[wdec.idx].limit = merge(st_r.win[wdec.idx].limit,
						reg_req_i.wdata, reg_req_i.be);
				end
				default: begin
					st_nxt.win[wdec.idx] = st_r.win[wdec.idx];
				end
			endcase
		end

		// Register reads; unmapped offsets return zero
		if (reg_req_i.rd) begin
			st_nxt.rd_valid = 1'b1;
			st_nxt.rd_data  = '0;
			if (rdec.hit) begin
				unique case (rdec.kind)
					utw_pkg::KIND_CTRL: begin
						st_nxt.rd_data = 32'(ctrl_word(st_r.win[rdec.idx]));
					end
					utw_pkg::KIND_BASE: begin
						st_nxt.rd_data = st_r.win[rdec.idx].base;
					end
					utw_pkg::KIND_LIMIT: begin
						st_nxt.rd_data = st_r.win[rdec.idx].limit;
					end
					default: begin
						st_nxt.rd_data = '0;
					end
				endcase
			end
		end

		// Upstream class mapping, registered: the class of a request shows
		// one cycle after the request
		st_nxt.map = pick_map(up_req_i.valid, win_hit, st_r);
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	// The read answer is part of the state, so a low clock enable also
	// holds a pending answer instead of dropping it
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= '0;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	// Every output leaves straight from a flip-flop
	assign reg_rdata_o  = st_r.rd_data;
	assign reg_rvalid_o = st_r.rd_valid;
	assign up_map_o     = st_r.map;

endmodule

// File: common/utw_pkg.sv
// Behaviour
// - Control bits 15:4 read zero, ignore writes
// - Control bits 3:1 hold class select
// - Disabled window never affects upstream traffic
// - Enabled window assigns its class on hit
// - Each window has read/write 32-bit base
// - Each window has read/write 32-bit limit
// - Base and limit store even while disabled
// - Reset clears control, base and limit
// - Window registers at 14h-1Ch and 20h-28h
// - Nonzero class only with global permit set
package utw_pkg;

	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int ADDR_W  = 8;
	localparam int DATA_W  = 32;
	localparam int BE_W    = 4;
	localparam int CLASS_W = 3;
	localparam int NUM_WIN = 2;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_WIN1_CONTROL = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_WIN1_BASE    = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_WIN1_LIMIT   = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_WIN2_CONTROL = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_WIN2_BASE    = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_WIN2_LIMIT   = 8'h28;

	// ---------------------------------------------------------------
	// Control field layout and reset values
	// ---------------------------------------------------------------
	localparam int CTRL_EN_BIT  = 0;
	localparam int CTRL_CLS_LSB = 1;
	localparam int CTRL_CLS_MSB = 3;
	localparam int CTRL_W       = 16;

	localparam logic [CTRL_W-1:0]  CTRL_RST  = 16'h0000;
	localparam logic [DATA_W-1:0]  ADDR_RST  = 32'h0000_0000;
	localparam logic [CLASS_W-1:0] CLASS_ZERO = 3'h0;

	// Register kinds inside one window
	localparam logic [1:0] KIND_CTRL  = 2'h0;
	localparam logic [1:0] KIND_BASE  = 2'h1;
	localparam logic [1:0] KIND_LIMIT = 2'h2;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [BE_W-1:0]   be;
	} utw_reg_req_s;

	typedef struct packed {
		logic              valid;
		logic [DATA_W-1:0] addr;
	} utw_up_req_s;

	typedef struct packed {
		logic               valid;
		logic               hit;
		logic [CLASS_W-1:0] class_select;
	} utw_up_map_s;

	typedef struct packed {
		logic       hit;
		logic       idx;
		logic [1:0] kind;
	} utw_dec_s;

	typedef struct packed {
		logic               window_map_enable;
		logic [CLASS_W-1:0] class_select;
		logic [DATA_W-1:0]  base;
		logic [DATA_W-1:0]  limit;
	} utw_win_s;

	typedef struct packed {
		utw_win_s [NUM_WIN-1:0] win;
		logic [DATA_W-1:0]      rd_data;
		logic                   rd_valid;
		utw_up_map_s            map;
	} utw_state_s;

endpackage

// File: bench/utw_window_map_props.sv
`timescale 1ns/1ps
module utw_window_map_props (
	input wire logic                  sys_clk_i,
	input wire logic                  nrst_i,
	input wire logic                  ce_i,
	input wire utw_pkg::utw_reg_req_s reg_req_i,
	input wire logic [31:0]           reg_rdata_o,
	input wire logic                  reg_rvalid_o,
	input wire logic                  global_iso_permit_i,
	input wire utw_pkg::utw_up_req_s  up_req_i,
	input wire utw_pkg::utw_up_map_s  up_map_o
);
	// ----
	// Properties
	// ----
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	a_map_valid_copy: assert property (ce_i |=> up_map_o.valid == $past(up_req_i.valid))
		else $error("map valid");
	a_permit_low_zero: assert property (ce_i && !global_iso_permit_i |=>
		!up_map_o.hit && up_map_o.class_select == 3'h0) else $error("permit");
	a_miss_class_zero: assert property (!up_map_o.hit |-> up_map_o.class_select == 3'h0)
		else $error("miss class");
	a_hit_has_valid: assert property (up_map_o.hit |-> up_map_o.valid)
		else $error("hit valid");
	a_read_answered: assert property (ce_i && reg_req_i.rd |=> reg_rvalid_o)
		else $error("rvalid");
	a_read_quiet: assert property (ce_i && !reg_req_i.rd |=> !reg_rvalid_o)
		else $error("stray rvalid");
	a_ctrl_rsvd_zero: assert property (ce_i && reg_req_i.rd &&
		(reg_req_i.addr == 8'h14 || reg_req_i.addr == 8'h20) |=> reg_rdata_o[31:4] == 28'h0)
		else $error("reserved");
	a_unmapped_zero: assert property (ce_i && reg_req_i.rd && reg_req_i.addr == 8'h2C
		|=> reg_rdata_o == 32'h0) else $error("unmapped");
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic                  sys_clk_i = 1'b0;
	logic                  nrst_i = 1'b0;
	logic                  ce_i = 1'b1;
	logic                  global_iso_permit_i = 1'b0;
	utw_pkg::utw_reg_req_s reg_req_i = '0;
	utw_pkg::utw_up_req_s  up_req_i = '0;
	logic [31:0]           reg_rdata_o;
	logic                  reg_rvalid_o;
	utw_pkg::utw_up_map_s  up_map_o;
	int                    fails = 0;
	int                    total_checks = 0;
	logic [3:0]            c [2];
	logic [31:0]           b [2];
	logic [31:0]           l [2];

	utw_window_map u_dut (.sys_clk_i, .nrst_i, .ce_i, .reg_req_i, .reg_rdata_o,
		.reg_rvalid_o, .global_iso_permit_i, .up_req_i, .up_map_o);

	initial forever #2 sys_clk_i = ~sys_clk_i;

	// ----
	// Helpers
	// ----
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %0t saw %h want %h", $time, seen, exp);
		end
	endtask

	// Strobe stays up between back-to-back accesses
	task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] be);
		reg_req_i = '{1'b1, 1'b0, a, d, be};
		@(negedge sys_clk_i);
	endtask

	task automatic rd(logic [7:0] a, logic [31:0] exp);
		reg_req_i = '{1'b0, 1'b1, a, 32'h0, 4'h0};
		@(negedge sys_clk_i);
		chk({31'h0, reg_rvalid_o}, 32'h1);
		chk(reg_rdata_o, exp);
	endtask

	// Reset from any point; every register must come back as zero
	task automatic do_reset();
		nrst_i = 1'b0;
		repeat (10) @(negedge sys_clk_i);
		chk({26'h0, up_map_o, reg_rvalid_o}, 32'h0);
		chk(reg_rdata_o, 32'h0);
		nrst_i = 1'b1;
		for (int k = 0; k < 6; k++) rd(8'h14 + 8'(4 * k), 32'h0);
	endtask

	// Window 1 is scanned last so it wins on overlap
	function automatic logic [4:0] exp_map(logic [31:0] a, logic v, logic p);
		exp_map = {v, 4'h0};
		for (int i = 1; i >= 0; i--)
			if (v && p && c[i][0] && a >= b[i] && a <= l[i]) exp_map = {2'h3, c[i][3:1]};
	endfunction

	task automatic up(logic [31:0] a, logic v, logic p);
		up_req_i = '{v, a};
		global_iso_permit_i = p;
		@(negedge sys_clk_i);
		chk({up_map_o.valid, up_map_o.hit, up_map_o.class_select}, exp_map(a, v, p));
	endtask

	task automatic wrap_up();
		if (fails == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----
	// Sequence
	// ----
	initial begin
		void'($urandom(62021));
		do_reset();
		rd(8'h2C, 32'h0);
		wr(8'h20, 32'hFFFF_FFFF, 4'hF);
		rd(8'h20, 32'h0000_000F);
		wr(8'h18, 32'hA5A5_A5A5, 4'hF);
		wr(8'h18, 32'h0000_003C, 4'h1);
		rd(8'h18, 32'hA5A5_A53C);
		wr(8'h28, 32'h1234_5678, 4'hF);
		rd(8'h28, 32'h1234_5678);
		repeat (40) begin
			for (int i = 0; i < 2; i++) begin
				c[i] = 4'($urandom);
				b[i] = $urandom;
				if (i == 1 && $urandom_range(1)) b[1] = b[0];
				l[i] = b[i] + 32'($urandom_range(64));
				wr(8'h14 + 8'(12 * i), {28'($urandom), c[i]}, 4'hF);
				wr(8'h18 + 8'(12 * i), b[i], 4'hF);
				wr(8'h1C + 8'(12 * i), l[i], 4'hF);
				rd(8'h14 + 8'(12 * i), {28'h0, c[i]});
			end
			for (int k = 0; k < 2; k++) begin
				up(b[k], 1'b1, 1'b1);
				up(l[k] + 32'h1, 1'b1, 1'b1);
				up(l[k], 1'(k), 1'($urandom));
				up(b[k] - 32'h1, 1'($urandom), 1'b1);
			end
		end
		// Control writes need byte 0; without it nothing changes
		wr(8'h14, 32'h0000_000F, 4'hE);
		rd(8'h14, {28'h0, c[0]});
		// A low clock enable drops the write and holds the read answer
		ce_i = 1'b0;
		wr(8'h18, ~b[0], 4'hF);
		chk({31'h0, reg_rvalid_o}, 32'h1);
		chk(reg_rdata_o, {28'h0, c[0]});
		ce_i = 1'b1;
		rd(8'h18, b[0]);
		wr(8'h24, 32'h0, 4'h0);
		chk(reg_rdata_o, b[0]);
		// Reset in mid-run leaves every window inert
		do_reset();
		c = '{4'h0, 4'h0};
		up(b[0], 1'b1, 1'b1);
		up(b[1], 1'b1, 1'b1);
		wrap_up();
	end

	initial begin
		#40000;
		fails++;
		wrap_up();
	end
endmodule

bind utw_window_map utw_window_map_props u_props (.sys_clk_i, .nrst_i, .ce_i, .reg_req_i,
	.reg_rdata_o, .reg_rvalid_o, .global_iso_permit_i, .up_req_i, .up_map_o);
